// ### rtl/pfs_pkg.sv
package pfs_pkg;
	// register byte addresses on the avalon slave
	localparam logic [4:0] PFS_OFF_TIMER_CTRL  = 5'h00;
	localparam logic [4:0] PFS_OFF_PRESC_SEL   = 5'h04;
	localparam logic [4:0] PFS_OFF_OUT_LEVEL   = 5'h08;
	localparam logic [4:0] PFS_OFF_STOP_CTRL   = 5'h0c;
	localparam logic [4:0] PFS_OFF_TRIG_GATE   = 5'h10;
	localparam logic [4:0] PFS_OFF_RELEASE     = 5'h14;
	localparam logic [4:0] PFS_OFF_PERIOD_DUTY = 5'h18;
	localparam logic [4:0] PFS_OFF_STATUS      = 5'h1c;

	// timer control fields
	localparam int PFS_RUN_BIT   = 7;
	localparam int PFS_CKSEL_BIT = 4;
	localparam int PFS_MODE_LSB  = 0;
	localparam logic [1:0] PFS_MODE_STANDALONE = 2'h0;
	localparam logic [1:0] PFS_MODE_INTERLEAVE = 2'h3;

	// prescaler select fields, selections above this are prohibited
	localparam int PFS_PSA_LSB = 0;
	localparam int PFS_PSB_LSB = 4;
	localparam logic [2:0] PFS_PS_MAX = 3'h5;

	// output level control fields
	localparam int PFS_TOL_LSB = 2;
	localparam int PFS_TOD_LSB = 0;

	// forced stop control fields
	localparam int PFS_S2_EN_LSB   = 12;
	localparam int PFS_S2_MODE_BIT = 8;
	localparam int PFS_S1_EN_LSB   = 4;
	localparam int PFS_S1_DEFER    = 3;
	localparam int PFS_S1_LVLGATE  = 2;
	localparam int PFS_SAFE_LSB    = 0;
	localparam logic [15:0] PFS_STOP_CTRL_MASK = 16'hf13f;

	// reset values
	localparam logic [7:0]  PFS_TIMER_CTRL_RST = 8'h00;
	localparam logic [7:0]  PFS_PRESC_SEL_RST  = 8'h00;
	localparam logic [3:0]  PFS_OUT_LEVEL_RST  = 4'h0;
	localparam logic [15:0] PFS_STOP_CTRL_RST  = 16'h0000;
	localparam logic [1:0]  PFS_TRIG_GATE_RST  = 2'h0;
	localparam logic [15:0] PFS_PERIOD_RST     = 16'h00ff;
	localparam logic [15:0] PFS_DUTY_RST       = 16'h0080;
	localparam logic [15:0] PFS_CNT_PRESET     = 16'hffff;

	// trigger source indices after synchronisation
	localparam int PFS_TRIG_N = 4;
	localparam int PFS_SRC_CMP_A = 0;
	localparam int PFS_SRC_CMP_B = 1;
	localparam int PFS_SRC_IRQ_A = 2;
	localparam int PFS_SRC_IRQ_B = 3;
endpackage

// ### rtl/pfs_top.sv
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
// How it works
// - mode field 00 is standalone, 11 is interleaved output, others refused.
// - with clock select at 1 the counter steps on prescaler clock b.
// - each output's active-level bit: 0 active high, 1 active low.
// - each output's default-level bit: 0 low, 1 high while idle.
// - stop 2 takes either irq or comparator, each enabled by its own bit.
// - stop 2 clears at next period end, or after the reverse edge if set.
// - stop 1 takes comparator triggers only, each enabled by its own bit.
// - stop 1 clears on a release write, or at the period end after it.
// - with the level gate bit set, a release during active trigger is void.
// - a pending period clear waits while the timer is not running.
// - the safe-state field picks forced levels for stop 1 and stop 2.
// - a per-output gate bit at 0 blocks that output's stop triggers.
// - with clock select at 0 the counter steps on prescaler clock a.
// - run at 0 stops and presets the counter to all ones.
module pfs_top
	import pfs_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        comparator_a_i,
	input  wire logic        comparator_b_i,
	input  wire logic        ext_irq_a_i,
	input  wire logic        ext_irq_b_i,
	output logic             pwm_out_a_o,
	output logic             pwm_out_b_o,
	output logic             pwm_out_a_oe_o,
	output logic             pwm_out_b_oe_o
);
	logic [7:0]  timer_ctrl;
	logic [7:0]  presc_sel;
	logic [3:0]  out_level;
	logic [15:0] stop_ctrl;
	logic [1:0]  trig_gate;
	logic [15:0] period;
	logic [15:0] duty;
	logic [15:0] cnt;
	logic [4:0]  div;
	logic        acc_wr;
	logic        rel_wr;
	logic [31:0] wd;
	logic [31:0] next_rdata;
	logic [1:0]  next_mode;
	logic        timer_run;
	logic        timer_clock_sel;
	logic        tick;
	logic        period_end;
	logic [15:0] half;
	logic [16:0] phase_b;
	logic [1:0]  pwm_act;
	logic [1:0]  stop1;
	logic [1:0]  pend1;
	logic [1:0]  stop2;
	logic [1:0]  arm2;
	logic [1:0]  out_q;
	logic [1:0]  oe_q;
	logic        trig1_rise;
	logic        trig1_lvl;
	logic        trig2_rise;
	logic        trig2_fall;
	logic [3:0]  en1;
	logic [3:0]  en2;

	pfs_trig_if #(.N(PFS_TRIG_N)) trig ();

	pfs_trig_sync #(.N(PFS_TRIG_N)) u_sync (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.raw_i     ({ext_irq_b_i, ext_irq_a_i,
		              comparator_b_i, comparator_a_i}),
		.trig      (trig.src)
	);

	// byte lanes merge new data into the old word
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// prescaler tap: sel n ticks once every 2**n clocks
	function automatic logic ps_tick(input logic [2:0] sel,
		input logic [4:0] d);
		logic [4:0] m;
		m = 5'((6'h01 << sel) - 6'h01);
		return (sel <= PFS_PS_MAX) && ((d & m) == m);
	endfunction

	assign timer_run       = timer_ctrl[PFS_RUN_BIT];
	assign timer_clock_sel = timer_ctrl[PFS_CKSEL_BIT];
	assign acc_wr = avs_write_i && !avs_waitrequest_o;
	assign rel_wr = acc_wr && (avs_address_i == PFS_OFF_RELEASE)
		&& avs_byteenable_i[0] && avs_writedata_i[0];

	// one wait cycle per access keeps read data a registered value
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !((avs_read_i || avs_write_i)
				&& avs_waitrequest_o);
	end

	always_comb
	begin
		next_rdata = 32'h0;
		unique case (avs_address_i)
			PFS_OFF_TIMER_CTRL:  next_rdata = {24'h0, timer_ctrl};
			PFS_OFF_PRESC_SEL:   next_rdata = {24'h0, presc_sel};
			PFS_OFF_OUT_LEVEL:   next_rdata = {28'h0, out_level};
			PFS_OFF_STOP_CTRL:   next_rdata = {16'h0, stop_ctrl};
			PFS_OFF_TRIG_GATE:   next_rdata = {30'h0, trig_gate};
			PFS_OFF_PERIOD_DUTY: next_rdata = {duty, period};
			PFS_OFF_STATUS:
				next_rdata = {cnt, 8'h0, arm2, pend1, stop2, stop1};
			default:             next_rdata = 32'h0; // release, unmapped
		endcase
	end

	// read data loaded in the wait cycle, stands when waitrequest drops
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			avs_readdata_o <= 32'h0;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= next_rdata;
	end

	always_comb
	begin
		wd = 32'h0;
		unique case (avs_address_i)
			PFS_OFF_TIMER_CTRL:  wd = {24'h0, timer_ctrl};
			PFS_OFF_PRESC_SEL:   wd = {24'h0, presc_sel};
			PFS_OFF_OUT_LEVEL:   wd = {28'h0, out_level};
			PFS_OFF_STOP_CTRL:   wd = {16'h0, stop_ctrl};
			PFS_OFF_TRIG_GATE:   wd = {30'h0, trig_gate};
			PFS_OFF_PERIOD_DUTY: wd = {duty, period};
			default:             wd = 32'h0;
		endcase
		wd = be_merge(wd, avs_writedata_i, avs_byteenable_i);
		// prohibited mode codes leave the old mode in place
		next_mode = wd[PFS_MODE_LSB +: 2];
		if (next_mode != PFS_MODE_STANDALONE
			&& next_mode != PFS_MODE_INTERLEAVE)
			next_mode = timer_ctrl[PFS_MODE_LSB +: 2];
	end

	// software registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			timer_ctrl <= PFS_TIMER_CTRL_RST;
			presc_sel  <= PFS_PRESC_SEL_RST;
			out_level  <= PFS_OUT_LEVEL_RST;
			stop_ctrl  <= PFS_STOP_CTRL_RST;
			trig_gate  <= PFS_TRIG_GATE_RST;
			period     <= PFS_PERIOD_RST;
			duty       <= PFS_DUTY_RST;
		end
		else if (acc_wr)
		begin
			unique case (avs_address_i)
				PFS_OFF_TIMER_CTRL:
					timer_ctrl <= {wd[PFS_RUN_BIT], 2'h0,
						wd[PFS_CKSEL_BIT], 2'h0, next_mode};
				PFS_OFF_PRESC_SEL:   presc_sel <= wd[7:0] & 8'h77;
				PFS_OFF_OUT_LEVEL:   out_level <= wd[3:0];
				PFS_OFF_STOP_CTRL:
					stop_ctrl <= wd[15:0] & PFS_STOP_CTRL_MASK;
				PFS_OFF_TRIG_GATE:   trig_gate <= wd[1:0];
				PFS_OFF_PERIOD_DUTY:
				begin
					period <= wd[15:0];
					duty   <= wd[31:16];
				end
				default: ;
			endcase
		end
	end

	// free divider feeding both prescaler taps
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			div <= 5'h0;
		else
			div <= div + 5'h1;
	end

	assign tick = timer_clock_sel
		? ps_tick(presc_sel[PFS_PSB_LSB +: 3], div)
		: ps_tick(presc_sel[PFS_PSA_LSB +: 3], div);
	// no period end while stopped, so pending clears wait for restart
	assign period_end = timer_run && tick && (cnt == period);

	// up counter; the preset is not below any period so it wraps to zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt <= PFS_CNT_PRESET;
		else if (!timer_run)
			cnt <= PFS_CNT_PRESET;
		else if (tick)
			cnt <= (cnt >= period) ? 16'h0 : cnt + 16'h1;
	end

	// interleaved mode runs output b half a period behind output a
	assign half    = period >> 1;
	assign phase_b = (cnt >= half) ? {1'b0, cnt - half}
		: 17'({1'b0, cnt} + {1'b0, period} + 17'h1 - {1'b0, half});
	assign pwm_act[0] = timer_run && (cnt < duty);
	assign pwm_act[1] = (timer_ctrl[PFS_MODE_LSB +: 2]
		== PFS_MODE_INTERLEAVE)
		? (timer_run && (phase_b < {1'b0, duty})) : pwm_act[0];

	// trigger selection per stop function
	assign en2 = stop_ctrl[PFS_S2_EN_LSB +: 4];
	assign en1 = {2'b00, stop_ctrl[PFS_S1_EN_LSB +: 2]};
	assign trig1_rise = |(trig.rise & en1);
	assign trig1_lvl  = |(trig.lvl & en1);
	assign trig2_rise = |(trig.rise & en2);
	assign trig2_fall = |(trig.fall & en2);

	for (genvar n = 0; n < 2; n++)
	begin : g_out
		logic g;
		logic set1;
		logic set2;
		logic vrel;
		logic s1_q;
		logic p1_q;
		logic s2_q;
		logic a2_q;
		logic norm;
		logic next_out;
		logic next_oe;
		logic o_q;
		logic e_q;

		assign g    = trig_gate[n];
		assign set1 = g && trig1_rise;
		assign set2 = g && trig2_rise;
		assign vrel = rel_wr && !(stop_ctrl[PFS_S1_LVLGATE]
			&& trig1_lvl);

		// stop 1: new trigger wins over any clear in the same cycle
		always_ff @(posedge clk_sys_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				s1_q <= 1'b0;
			else if (set1)
				s1_q <= 1'b1;
			else if ((!stop_ctrl[PFS_S1_DEFER] && vrel)
				|| (p1_q && period_end))
				s1_q <= 1'b0;
		end

		// deferred release waits for the period end; a release landing
		// on a period end is kept for the next one instead of being lost
		always_ff @(posedge clk_sys_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				p1_q <= 1'b0;
			else if (set1)
				p1_q <= 1'b0;
			else if (stop_ctrl[PFS_S1_DEFER] && vrel && s1_q
				&& !p1_q)
				p1_q <= 1'b1;
			else if (period_end)
				p1_q <= 1'b0;
		end

		// stop 2 clears on a period end, after reverse edge if asked
		always_ff @(posedge clk_sys_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				s2_q <= 1'b0;
			else if (set2)
				s2_q <= 1'b1;
			else if (period_end
				&& (!stop_ctrl[PFS_S2_MODE_BIT] || a2_q))
				s2_q <= 1'b0;
		end

		// reverse edge seen; an edge on a period end still arms
		always_ff @(posedge clk_sys_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
				a2_q <= 1'b0;
			else if (set2)
				a2_q <= 1'b0;
			else if (g && trig2_fall && s2_q && !a2_q)
				a2_q <= 1'b1;
			else if (period_end)
				a2_q <= 1'b0;
		end

		// stop 1 outranks stop 2 since it may float the pin
		always_comb
		begin
			norm = timer_run ? (pwm_act[n] ^ out_level[PFS_TOL_LSB + n])
				: out_level[PFS_TOD_LSB + n];
			next_oe  = 1'b1;
			next_out = norm;
			if (s1_q)
			begin
				next_oe  = stop_ctrl[PFS_SAFE_LSB + 1];
				next_out = stop_ctrl[PFS_SAFE_LSB + 1]
					&& stop_ctrl[PFS_SAFE_LSB];
			end
			else if (s2_q)
				next_out = stop_ctrl[PFS_SAFE_LSB];
		end

		always_ff @(posedge clk_sys_i or negedge arst_n_i)
		begin
			if (!arst_n_i)
			begin
				o_q <= 1'b0;
				e_q <= 1'b1;
			end
			else
			begin
				o_q <= next_out;
				e_q <= next_oe;
			end
		end

		assign stop1[n] = s1_q;
		assign pend1[n] = p1_q;
		assign stop2[n] = s2_q;
		assign arm2[n]  = a2_q;
		assign out_q[n] = o_q;
		assign oe_q[n]  = e_q;
	end

	assign pwm_out_a_o    = out_q[0];
	assign pwm_out_b_o    = out_q[1];
	assign pwm_out_a_oe_o = oe_q[0];
	assign pwm_out_b_oe_o = oe_q[1];

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	AST_MODE_LEGAL: assert property (
		timer_ctrl[1:0] != 2'h1 && timer_ctrl[1:0] != 2'h2)
		else $error("prohibited timer mode stored");
	AST_CLK_B: assert property (
		(timer_run && timer_clock_sel && cnt != 16'hffff
		&& !ps_tick(presc_sel[6:4], div)) |=> $stable(cnt))
		else $error("counter moved without clock b tick");
	AST_CLK_A: assert property (
		(timer_run && !timer_clock_sel && presc_sel[2:0] == 3'h0
		&& cnt < period && $stable(timer_run)) |=> cnt == $past(cnt) + 16'h1)
		else $error("counter missed undivided clock a");
	AST_PRESET: assert property (
		!timer_run |=> cnt == 16'hffff)
		else $error("stopped counter not at all ones");
	AST_DEFAULT: assert property (
		(!timer_run && !stop1[0] && !stop2[0])
		|=> pwm_out_a_o == $past(out_level[0]) && pwm_out_a_oe_o)
		else $error("idle output not at default level");
	AST_STOP1_SET: assert property (
		(trig_gate[0] && trig.rise[0] && stop_ctrl[4]) |=> stop1[0])
		else $error("comparator trigger did not start stop 1");
	AST_STOP2_SET: assert property (
		(trig_gate[1] && trig.rise[3] && stop_ctrl[15]) |=> stop2[1])
		else $error("irq trigger did not start stop 2");
	AST_GATE: assert property (
		(!trig_gate[1] && !stop1[1] && !stop2[1])
		|=> !stop1[1] && !stop2[1])
		else $error("gated output entered forced stop");
	AST_REL_VOID: assert property (
		(stop1[0] && rel_wr && stop_ctrl[2] && trig1_lvl && !period_end)
		|=> stop1[0] && !pend1[0] || $past(pend1[0]))
		else $error("release honoured while trigger active");
	AST_DEFER: assert property (
		(stop1[0] && stop_ctrl[3] && !period_end) |=> stop1[0])
		else $error("deferred stop 1 cleared before period end");
	AST_HOLD: assert property (
		(!timer_run && stop2[0]) |=> stop2[0])
		else $error("forced stop left while timer stopped");
	AST_HIZ: assert property (
		(stop1[0] && !stop_ctrl[1]) |=> !pwm_out_a_oe_o)
		else $error("stop 1 high impedance not applied");
	AST_S2_LEVEL: assert property (
		(stop2[1] && !stop1[1]) |=> pwm_out_b_oe_o
		&& pwm_out_b_o == $past(stop_ctrl[0]))
		else $error("stop 2 safe level wrong");
	AST_ACT_LOW: assert property (
		(timer_run && !stop1[0] && !stop2[0] && pwm_act[0] && out_level[2])
		|=> !pwm_out_a_o)
		else $error("active low output drove high");
	AST_S2_CLEAR: assert property (
		(stop2[0] && !stop_ctrl[8] && period_end && !trig2_rise)
		|=> !stop2[0])
		else $error("stop 2 missed period end clear");
endmodule // pfs_top

// ### rtl/pfs_trig_if.sv
`timescale 1ns/1ps
interface pfs_trig_if #(parameter int N = 4);
	logic [N-1:0] lvl;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface // pfs_trig_if

// ### rtl/pfs_trig_sync.sv
`timescale 1ns/1ps
module pfs_trig_sync
	import pfs_pkg::*;
#(
	parameter int N = PFS_TRIG_N
)(
	input  wire logic         clk_sys_i,
	input  wire logic         arst_n_i,
	input  wire logic [N-1:0] raw_i,
	pfs_trig_if.src           trig
);
	logic [N-1:0] meta;
	logic [N-1:0] sync;
	logic [N-1:0] sync_d;

	// two stages before anyone looks, third only for edges
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta   <= '0;
			sync   <= '0;
			sync_d <= '0;
		end
		else
		begin
			meta   <= raw_i;
			sync   <= meta;
			sync_d <= sync;
		end
	end

	assign trig.lvl  = sync;
	assign trig.rise = sync & ~sync_d;
	assign trig.fall = ~sync & sync_d;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	AST_SYNC_DELAY: assert property (
		##2 (trig.lvl == $past(raw_i, 2)))
		else $error("trigger level not two cycles behind pin");
endmodule // pfs_trig_sync

// ### test/pfs_pin_model.sv
`timescale 1ns/1ps
// far side of the block: comparator and interrupt pins, always driven
module pfs_pin_model
	import pfs_pkg::*;
(
	input  wire logic                  clk_sys_i,
	input  wire logic [PFS_TRIG_N-1:0] want_i,
	input  wire logic [1:0]            lag_i,
	output logic      [PFS_TRIG_N-1:0] pin_o
);
	logic [1:0] wait_cnt;

	initial
	begin
		pin_o = '0;
		wait_cnt = 2'h0;
	end

	// a new level reaches the pins only after lag_i cycles, so both a
	// prompt and a slow source are seen; the level then holds until told
	always @(posedge clk_sys_i)
	begin
		if (want_i != pin_o && wait_cnt == lag_i)
			pin_o <= want_i;
		if (want_i != pin_o && wait_cnt != lag_i)
			wait_cnt <= wait_cnt + 2'h1;
		else
			wait_cnt <= 2'h0;
	end
endmodule // pfs_pin_model

// ### test/pfs_top_bench.sv
`timescale 1ns/1ps
// self-checking bench for the forced output stop block
module pfs_top_bench
	import pfs_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [4:0]  avs_address_i = 5'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        pwm_out_a_o;
	logic        pwm_out_b_o;
	logic        pwm_out_a_oe_o;
	logic        pwm_out_b_oe_o;
	logic [3:0]  want = 4'h0;
	logic [1:0]  lag = 2'h0;
	logic [3:0]  pin;
	logic [31:0] q;
	logic [31:0] d;
	logic [15:0] c0;
	logic [1:0]  keep;
	logic [1:0]  safe;
	logic [2:0]  psa;
	logic        cksel;
	int          modes[4] = '{3, 1, 2, 0};
	int          n_mismatch = 0;
	int          compares = 0;
	int          seed = 21850;

	pfs_top u_dut (
		.clk_sys_i        (clk_sys_i),
		.arst_n_i         (arst_n_i),
		.avs_address_i    (avs_address_i),
		.avs_read_i       (avs_read_i),
		.avs_write_i      (avs_write_i),
		.avs_writedata_i  (avs_writedata_i),
		.avs_byteenable_i (avs_byteenable_i),
		.avs_readdata_o   (avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.comparator_a_i   (pin[PFS_SRC_CMP_A]),
		.comparator_b_i   (pin[PFS_SRC_CMP_B]),
		.ext_irq_a_i      (pin[PFS_SRC_IRQ_A]),
		.ext_irq_b_i      (pin[PFS_SRC_IRQ_B]),
		.pwm_out_a_o      (pwm_out_a_o),
		.pwm_out_b_o      (pwm_out_b_o),
		.pwm_out_a_oe_o   (pwm_out_a_oe_o),
		.pwm_out_b_oe_o   (pwm_out_b_oe_o)
	);

	pfs_pin_model u_pins (
		.clk_sys_i(clk_sys_i),
		.want_i   (want),
		.lag_i    (lag),
		.pin_o    (pin)
	);

	// 20 MHz system clock
	initial
	begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one avalon access; the request holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= dat;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 40);
		q = avs_readdata_o;
		chk("waitrequest", 32'h0, {31'h0, avs_waitrequest_o});
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [4:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, exp, q);
	endtask

	// lag is random so the pins settle promptly or slowly
	task automatic drive_pins(input logic [3:0] v);
		lag <= 2'($random(seed));
		want <= v;
		repeat (12) @(posedge clk_sys_i);
	endtask

	// {oe, level} per output; the level is ignored while floating
	task automatic chk_pins(input string nm, input logic [1:0] ea,
		input logic [1:0] eb);
		chk(nm, {28'h0, ea[1], ea[1] & ea[0], eb[1], eb[1] & eb[0]},
			{28'h0, pwm_out_a_oe_o, ea[1] & pwm_out_a_o,
			pwm_out_b_oe_o, eb[1] & pwm_out_b_o});
	endtask

	function automatic logic [1:0] stop_lvl(input int fn,
		input logic [1:0] sel);
		if (fn == 1 && !sel[1])
			return 2'b00;
		return {1'b1, sel[0]};
	endfunction

	// a hang counts as a mismatch; the tests take under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		give_verdict;
	end

	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rd_chk("timer_ctrl", PFS_OFF_TIMER_CTRL, {24'h0, PFS_TIMER_CTRL_RST});
		rd_chk("presc", PFS_OFF_PRESC_SEL, {24'h0, PFS_PRESC_SEL_RST});
		rd_chk("out_level", PFS_OFF_OUT_LEVEL, {28'h0, PFS_OUT_LEVEL_RST});
		rd_chk("stop_ctrl", PFS_OFF_STOP_CTRL, {16'h0, PFS_STOP_CTRL_RST});
		rd_chk("gate", PFS_OFF_TRIG_GATE, {30'h0, PFS_TRIG_GATE_RST});
		rd_chk("per_duty", PFS_OFF_PERIOD_DUTY, {PFS_DUTY_RST, PFS_PERIOD_RST});
		rd_chk("unmapped", 5'h03, 32'h0);
		bus(1'b0, PFS_OFF_STATUS, 32'h0);
		chk("counter", {16'h0, PFS_CNT_PRESET}, {16'h0, q[31:16]});
		keep = 2'h0;
		foreach (modes[i])
		begin
			bus(1'b1, PFS_OFF_TIMER_CTRL, 32'(modes[i]));
			if (modes[i] == 0 || modes[i] == 3)
				keep = 2'(modes[i]);
			rd_chk("mode", PFS_OFF_TIMER_CTRL, {30'h0, keep});
		end
		repeat (8)
		begin
			d = $random(seed);
			bus(1'b1, PFS_OFF_STOP_CTRL, d);
			rd_chk("stop_ctrl", PFS_OFF_STOP_CTRL, d & {16'h0, PFS_STOP_CTRL_MASK});
			bus(1'b1, PFS_OFF_TRIG_GATE, d);
			rd_chk("gate", PFS_OFF_TRIG_GATE, {30'h0, d[1:0]});
			bus(1'b1, PFS_OFF_OUT_LEVEL, d);
			rd_chk("out_level", PFS_OFF_OUT_LEVEL, {28'h0, d[3:0]});
		end
		// only the low lanes written: period changes, duty keeps reset
		avs_byteenable_i <= 4'h3;
		bus(1'b1, PFS_OFF_PERIOD_DUTY, 32'h1234abcd);
		avs_byteenable_i <= 4'hf;
		rd_chk("lanes", PFS_OFF_PERIOD_DUTY, {PFS_DUTY_RST, 16'habcd});
		$display("test registers done");
		// ticks between two counter reads 32 cycles apart
		bus(1'b1, PFS_OFF_PERIOD_DUTY, 32'h0000ffff);
		for (int s = 0; s < 3; s++)
		begin
			psa = (s == 1) ? 3'h2 : 3'h0;
			cksel = (s == 2);
			bus(1'b1, PFS_OFF_PRESC_SEL, {25'h0, 3'h3, 1'b0, psa});
			bus(1'b1, PFS_OFF_TIMER_CTRL, {24'h0, 3'h4, cksel, 4'h0});
			bus(1'b0, PFS_OFF_STATUS, 32'h0);
			c0 = q[31:16];
			repeat (29) @(posedge clk_sys_i);
			bus(1'b0, PFS_OFF_STATUS, 32'h0);
			// counter difference taken modulo 16 bits across the preset wrap
			chk("ticks", 32'd32 >> (cksel ? 3 : psa),
				{16'h0, 16'(q[31:16] - c0)});
			bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h0);
		end
		bus(1'b0, PFS_OFF_STATUS, 32'h0);
		chk("preset", {16'h0, PFS_CNT_PRESET}, {16'h0, q[31:16]});
		$display("test prescaler done");
		bus(1'b1, PFS_OFF_TRIG_GATE, 32'h3);
		for (int v = 0; v < 4; v++)
		begin
			bus(1'b1, PFS_OFF_OUT_LEVEL, 32'(v));
			repeat (3) @(posedge clk_sys_i);
			chk_pins("default", {1'b1, v[0]}, {1'b1, v[1]});
		end
		bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h80);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, PFS_OFF_PERIOD_DUTY, {i[2] ? 16'hffff : 16'h0, 16'h7});
			bus(1'b1, PFS_OFF_OUT_LEVEL, {28'h0, i[1:0], 2'b00});
			repeat (3) @(posedge clk_sys_i);
			chk_pins("active", {1'b1, i[0] ^ i[2]}, {1'b1, i[1] ^ i[2]});
		end
		$display("test levels done");
		// running outputs sit high from here, stopped ones differ
		bus(1'b1, PFS_OFF_PERIOD_DUTY, 32'h7);
		bus(1'b1, PFS_OFF_OUT_LEVEL, 32'hc);
		for (int i = 0; i < 8; i++)
		begin
			safe = i[2:1];
			bus(1'b1, PFS_OFF_STOP_CTRL, (32'h10 << (i % 2)) | 32'(safe));
			drive_pins(4'hc | (4'h2 >> (i % 2)));
			chk_pins("no stop1", 2'b11, 2'b11);
			drive_pins(4'hf);
			chk_pins("stop1", stop_lvl(1, safe), stop_lvl(1, safe));
			drive_pins(4'h0);
			chk_pins("held", stop_lvl(1, safe), stop_lvl(1, safe));
			bus(1'b1, PFS_OFF_RELEASE, 32'h1);
			repeat (3) @(posedge clk_sys_i);
			chk_pins("released", 2'b11, 2'b11);
		end
		bus(1'b1, PFS_OFF_TRIG_GATE, 32'h1);
		bus(1'b1, PFS_OFF_STOP_CTRL, 32'h16);
		drive_pins(4'h1);
		chk_pins("gate", 2'b10, 2'b11);
		bus(1'b1, PFS_OFF_RELEASE, 32'h1);
		repeat (3) @(posedge clk_sys_i);
		chk_pins("void release", 2'b10, 2'b11);
		drive_pins(4'h0);
		bus(1'b1, PFS_OFF_RELEASE, 32'h1);
		repeat (3) @(posedge clk_sys_i);
		chk_pins("level release", 2'b11, 2'b11);
		bus(1'b1, PFS_OFF_TRIG_GATE, 32'h3);
		$display("test stop1 done");
		// from here running and idle outputs are low, stops force high
		bus(1'b1, PFS_OFF_OUT_LEVEL, 32'h0);
		bus(1'b1, PFS_OFF_STOP_CTRL, 32'h1b);
		drive_pins(4'h1);
		drive_pins(4'h0);
		bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h0);
		bus(1'b1, PFS_OFF_RELEASE, 32'h1);
		repeat (30) @(posedge clk_sys_i);
		chk_pins("kept stopped", 2'b11, 2'b11);
		bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h80);
		repeat (20) @(posedge clk_sys_i);
		chk_pins("restart clear", 2'b10, 2'b10);
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h0);
			bus(1'b1, PFS_OFF_STOP_CTRL, (32'h1000 << s) | 32'h1);
			drive_pins(~(4'h1 << s));
			chk_pins("no stop2", 2'b10, 2'b10);
			drive_pins(4'hf);
			chk_pins("stop2", 2'b11, 2'b11);
			bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h80);
			chk_pins("pending", 2'b11, 2'b11);
			repeat (20) @(posedge clk_sys_i);
			chk_pins("period clear", 2'b10, 2'b10);
			drive_pins(4'h0);
		end
		bus(1'b1, PFS_OFF_STOP_CTRL, 32'h4101);
		drive_pins(4'h4);
		repeat (30) @(posedge clk_sys_i);
		chk_pins("no reverse", 2'b11, 2'b11);
		drive_pins(4'h0);
		repeat (20) @(posedge clk_sys_i);
		chk_pins("reverse clear", 2'b10, 2'b10);
		$display("test stop2 done");
		// interleaved, period 7 duty 4: a on counts 0-3, b on 3-6,
		// so over one full period the outputs differ in 6 of 8 cycles
		bus(1'b1, PFS_OFF_STOP_CTRL, 32'h0);
		bus(1'b1, PFS_OFF_PERIOD_DUTY, 32'h00040007);
		bus(1'b1, PFS_OFF_TIMER_CTRL, 32'h83);
		@(posedge clk_sys_i);
		d = 32'h0;
		repeat (8)
		begin
			@(posedge clk_sys_i);
			d = d + 32'(pwm_out_a_o != pwm_out_b_o);
		end
		chk("interleave", 32'd6, d);
		$display("test interleave done");
		give_verdict;
	end
endmodule // pfs_top_bench
